// ===== iak_contend.sv
// constants for interrupt arbitration/acknowledge, and the serial contention engine
// Operation
// - each source holds a four-bit arbitration field, 0001 lowest, 1111 highest
// - a recognised request from a source whose field is zero becomes spurious
// - reset sets the unit's own field to 1111 and every other field to 0000
// - the unit's field stands for all external requests during contention
// - same-level simultaneous requests resolve by bit-serial contention of the fields
// - contention always runs; external acknowledge only when the unit wins
// - no contender during acknowledge ends in bus error and a spurious exception
// - winning internal source supplies its vector and terminates the cycle
// - tick timer requests beat external requests of the same level
// - sources respond only when the presented level equals their request level
// - handling starts at an instruction boundary, then status and pc are stacked
// - address space code is 111 during the acknowledge cycle
// - acknowledge address is all ones except bits 3 to 1 holding the level
// - the acknowledged level is latched into the interrupt priority mask
// - the mask blocks requests at or below its level
// - no matching source makes the spurious monitor raise the bus error line
package iak_pkg;
   localparam int FIELD_W = 4;
   localparam int LVL_W = 3;
   localparam int VEC_W = 8;
   localparam int ADDR_W = 24;
   localparam logic [FIELD_W-1:0] FIELD_SIU_RST = 4'hf;
   localparam logic [FIELD_W-1:0] FIELD_MOD_RST = 4'h0;
   localparam logic [FIELD_W-1:0] FIELD_ZERO = 4'h0;
   localparam logic [2:0] SPACE_CPU = 3'h7;
   localparam logic [2:0] SPACE_IDLE = 3'h0;
   localparam logic [19:0] ACK_ADDR_HI = 20'hfffff;
   localparam logic ACK_ADDR_B0 = 1'b1;
   localparam logic [LVL_W-1:0] MASK_RST = 3'h7;
   localparam int CLK_PERIOD_NS = 100;
   localparam int EXT_TIMEOUT_NS = 12800;
   localparam int EXT_TIMEOUT_CYC = (EXT_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 : EXT_TIMEOUT_NS / CLK_PERIOD_NS;
   localparam int TMO_W = 8;

   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_STACK = 6'b000010,
      ST_PRESENT = 6'b000100,
      ST_ARB = 6'b001000,
      ST_EXTBUS = 6'b010000,
      ST_FINISH = 6'b100000
   } iak_state_type;

   // index of the highest set bit of a level vector, zero when none
   function automatic logic [LVL_W-1:0] iak_top_level(input logic [7:1] lv);
      logic [LVL_W-1:0] r;
      r = '0;
      for (int k = 1; k < 8; k++) begin
         if (lv[k]) begin
            r = LVL_W'(k);
         end
      end
      return r;
   endfunction : iak_top_level
endpackage : iak_pkg

module iak_contend import iak_pkg::*; #(
   parameter int NSRC = 5
) (
   // clock and control
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   // contention request
   input wire logic start_i,
   input wire logic [NSRC-1:0] contend_i,
   input wire logic [NSRC*FIELD_W-1:0] field_i,
   // result
   output logic done_o,
   output logic [NSRC-1:0] alive_o
);
   logic busy_q;
   logic done_q;
   logic [1:0] bit_q;
   logic [NSRC-1:0] alive_q;
   logic [NSRC-1:0] bits;
   logic [NSRC-1:0] alive_d;

   always_comb begin
      for (int i = 0; i < NSRC; i++) begin
         bits[i] = field_i[i*FIELD_W + int'(bit_q)];
      end
      // a one on the shared line knocks out every contender showing zero
      alive_d = (|(alive_q & bits)) ? (alive_q & bits) : alive_q;
   end

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         bit_q <= 2'h3;
         alive_q <= '0;
      end else if (ce_i) begin
         done_q <= 1'b0;
         if (start_i) begin
            alive_q <= contend_i;
            bit_q <= 2'h3;
            busy_q <= 1'b1;
         end else if (busy_q) begin
            alive_q <= alive_d;
            bit_q <= bit_q - 2'h1;
            if (bit_q == 2'h0) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign done_o = done_q;
   assign alive_o = alive_q;

   a_contend_len: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      (start_i && ce_i) ##1 ce_i [*4] |=> done_q)
      else $error("contention did not finish after four bits");
   a_winner_single: assert property (@(posedge clk_i) disable iff (!arst_n_i)
      done_q |-> $onehot0(alive_q))
      else $error("contention left more than one winner");
endmodule : iak_contend

// ===== iak_top.sv
// interrupt arbitration and acknowledge sequencer
module iak_top import iak_pkg::*; #(
   parameter int NMOD = 4
) (
   // clock, reset, enable
   input wire logic CLOCK_I,
   input wire logic ARST_N_I,
   input wire logic CE_I,
   // internal module requests
   input wire logic [NMOD-1:0] MOD_REQ_I,
   input wire logic [NMOD*LVL_W-1:0] MOD_LEVEL_I,
   input wire logic [NMOD*VEC_W-1:0] MOD_VECTOR_I,
   output logic [NMOD-1:0] MOD_ACK_O,
   // periodic tick timer
   input wire logic TICK_REQ_I,
   input wire logic [LVL_W-1:0] TICK_LEVEL_I,
   input wire logic [VEC_W-1:0] TICK_VECTOR_I,
   output logic TICK_ACK_O,
   // arbitration field writes, index NMOD is the unit's own field
   input wire logic ARB_WR_I,
   input wire logic [$clog2(NMOD+1)-1:0] ARB_SEL_I,
   input wire logic [FIELD_W-1:0] ARB_DATA_I,
   // external interrupt pins and response, asynchronous
   input wire logic [7:1] IRQ_N_I,
   input wire logic EXT_TERM_N_I,
   input wire logic [VEC_W-1:0] EXT_DATA_I,
   output logic EXT_CYCLE_O,
   // processor core side
   input wire logic BOUNDARY_I,
   input wire logic MASK_LOAD_I,
   input wire logic [LVL_W-1:0] MASK_DATA_I,
   output logic STACK_O,
   output logic ACK_CYCLE_O,
   output logic [2:0] ADDRESS_SPACE_CODE_O,
   output logic [ADDR_W-1:0] ADDR_O,
   output logic [LVL_W-1:0] INTERRUPT_PRIORITY_MASK_O,
   output logic ACK_DONE_O,
   output logic [VEC_W-1:0] VECTOR_O,
   output logic BUS_ERROR_LINE_O,
   output logic SPURIOUS_O
);
   localparam int NSRC = NMOD + 1;
   localparam int SIU = NMOD;

   initial begin
      if (NMOD < 1 || NMOD > 14) begin
         $error("NMOD must lie between 1 and 14");
      end
      // the down-counter must hold the whole external wait
      if (EXT_TIMEOUT_CYC >= (1 << TMO_W)) begin
         $error("external timeout does not fit its counter");
      end
   end

   iak_state_type state_q;
   logic [NSRC*FIELD_W-1:0] field_q;
   logic [LVL_W-1:0] mask_q;
   logic [LVL_W-1:0] lvl_q;
   logic [7:1] irq_s1_q, irq_s2_q;
   logic term_s1_q, term_s2_q;
   logic [VEC_W-1:0] data_s1_q, data_s2_q;
   logic [TMO_W-1:0] tmo_q;
   logic cyc_q, ext_q, stack_q, done_q, bus_error_line_q, spur_q, tick_ack_q;
   logic [NMOD-1:0] mod_ack_q;
   logic [ADDR_W-1:0] addr_q;
   logic [2:0] space_q;
   logic [VEC_W-1:0] vec_q;
   logic start;
   logic arb_done;
   logic [NSRC-1:0] alive;
   logic [NSRC-1:0] contend;
   logic [7:1] req_lv;
   logic [LVL_W-1:0] pend_lvl;
   logic ext_at, tick_at;
   logic [VEC_W-1:0] win_vec;
   logic [FIELD_W-1:0] win_field;

   // pins cross in through two flops; the first stage feeds nothing else
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         irq_s1_q <= 7'h7f;
         irq_s2_q <= 7'h7f;
         term_s1_q <= 1'b1;
         term_s2_q <= 1'b1;
         data_s1_q <= '0;
         data_s2_q <= '0;
      end else if (CE_I) begin
         irq_s1_q <= IRQ_N_I;
         irq_s2_q <= irq_s1_q;
         term_s1_q <= EXT_TERM_N_I;
         term_s2_q <= term_s1_q;
         data_s1_q <= EXT_DATA_I;
         data_s2_q <= data_s1_q;
      end
   end

   // arbitration fields
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         field_q <= {FIELD_SIU_RST, {NMOD{FIELD_MOD_RST}}};
      end else if (CE_I && ARB_WR_I && int'(ARB_SEL_I) < NSRC) begin
         field_q[int'(ARB_SEL_I)*FIELD_W +: FIELD_W] <= ARB_DATA_I;
      end
   end

   always_comb begin
      req_lv = ~irq_s2_q;
      if (TICK_REQ_I && TICK_LEVEL_I != 3'h0) begin
         req_lv[TICK_LEVEL_I] = 1'b1;
      end
      for (int i = 0; i < NMOD; i++) begin
         if (MOD_REQ_I[i] && MOD_LEVEL_I[i*LVL_W +: LVL_W] != 3'h0) begin
            req_lv[MOD_LEVEL_I[i*LVL_W +: LVL_W]] = 1'b1;
         end
      end
      pend_lvl = iak_top_level(req_lv);
      // sources respond only to the level on the address bus
      tick_at = TICK_REQ_I && TICK_LEVEL_I == lvl_q;
      // level zero has no pin, so never index below the vector
      ext_at = 1'b0;
      if (lvl_q != '0) begin
         ext_at = !irq_s2_q[lvl_q];
      end
      for (int i = 0; i < NMOD; i++) begin
         contend[i] = MOD_REQ_I[i] && MOD_LEVEL_I[i*LVL_W +: LVL_W] == lvl_q;
      end
      // the unit's own field speaks for every external pin and the tick timer
      contend[SIU] = tick_at || ext_at;
      win_vec = TICK_VECTOR_I;
      win_field = field_q[SIU*FIELD_W +: FIELD_W];
      for (int i = 0; i < NMOD; i++) begin
         if (alive[i]) begin
            win_vec = MOD_VECTOR_I[i*VEC_W +: VEC_W];
            win_field = field_q[i*FIELD_W +: FIELD_W];
         end
      end
   end

   assign start = state_q == ST_PRESENT;

   iak_contend #(
      .NSRC(NSRC)
   ) u_contend (
      .clk_i(CLOCK_I),
      .arst_n_i(ARST_N_I),
      .ce_i(CE_I),
      .start_i(start),
      .contend_i(contend),
      .field_i(field_q),
      .done_o(arb_done),
      .alive_o(alive)
   );

   // sequencer and its outputs
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         state_q <= ST_IDLE;
         lvl_q <= '0;
         cyc_q <= 1'b0;
         ext_q <= 1'b0;
         stack_q <= 1'b0;
         done_q <= 1'b0;
         bus_error_line_q <= 1'b0;
         spur_q <= 1'b0;
         tick_ack_q <= 1'b0;
         mod_ack_q <= '0;
         addr_q <= '0;
         space_q <= SPACE_IDLE;
         vec_q <= '0;
         tmo_q <= '0;
      end else if (CE_I) begin
         stack_q <= 1'b0;
         done_q <= 1'b0;
         bus_error_line_q <= 1'b0;
         spur_q <= 1'b0;
         tick_ack_q <= 1'b0;
         mod_ack_q <= '0;
         case (state_q)
            ST_IDLE: begin
               // pending above the mask, taken only at a boundary
               if (pend_lvl > mask_q && BOUNDARY_I) begin
                  lvl_q <= pend_lvl;
                  stack_q <= 1'b1;
                  state_q <= ST_STACK;
               end
            end
            ST_STACK: begin
               cyc_q <= 1'b1;
               space_q <= SPACE_CPU;
               addr_q <= {ACK_ADDR_HI, lvl_q, ACK_ADDR_B0};
               state_q <= ST_PRESENT;
            end
            ST_PRESENT: begin
               state_q <= ST_ARB;
            end
            ST_ARB: begin
               if (arb_done) begin
                  if (alive == '0) begin
                     bus_error_line_q <= 1'b1;
                     spur_q <= 1'b1;
                     state_q <= ST_FINISH;
                  end else if (win_field == FIELD_ZERO) begin
                     spur_q <= 1'b1;
                     state_q <= ST_FINISH;
                  end else if (!alive[SIU]) begin
                     vec_q <= win_vec;
                     done_q <= 1'b1;
                     mod_ack_q <= alive[NMOD-1:0];
                     state_q <= ST_FINISH;
                  end else if (tick_at) begin
                     vec_q <= TICK_VECTOR_I;
                     done_q <= 1'b1;
                     tick_ack_q <= 1'b1;
                     state_q <= ST_FINISH;
                  end else begin
                     ext_q <= 1'b1;
                     tmo_q <= TMO_W'(EXT_TIMEOUT_CYC);
                     state_q <= ST_EXTBUS;
                  end
               end
            end
            ST_EXTBUS: begin
               tmo_q <= tmo_q - 8'h01;
               if (!term_s2_q) begin
                  vec_q <= data_s2_q;
                  done_q <= 1'b1;
                  state_q <= ST_FINISH;
               end else if (tmo_q == 8'h01) begin
                  bus_error_line_q <= 1'b1;
                  spur_q <= 1'b1;
                  state_q <= ST_FINISH;
               end
            end
            ST_FINISH: begin
               cyc_q <= 1'b0;
               ext_q <= 1'b0;
               space_q <= SPACE_IDLE;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end

   // priority mask, loaded from the address level as the cycle opens
   always_ff @(posedge CLOCK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         mask_q <= MASK_RST;
      end else if (CE_I) begin
         if (state_q == ST_STACK) begin
            mask_q <= lvl_q;
         end else if (MASK_LOAD_I && state_q == ST_IDLE) begin
            mask_q <= MASK_DATA_I;
         end
      end
   end

   assign MOD_ACK_O = mod_ack_q;
   assign TICK_ACK_O = tick_ack_q;
   assign EXT_CYCLE_O = ext_q;
   assign STACK_O = stack_q;
   assign ACK_CYCLE_O = cyc_q;
   assign ADDRESS_SPACE_CODE_O = space_q;
   assign ADDR_O = addr_q;
   assign INTERRUPT_PRIORITY_MASK_O = mask_q;
   assign ACK_DONE_O = done_q;
   assign VECTOR_O = vec_q;
   assign BUS_ERROR_LINE_O = bus_error_line_q;
   assign SPURIOUS_O = spur_q;

   a_space_cpu: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      cyc_q |-> space_q == 3'h7)
      else $error("address space code not cpu space during acknowledge");
   a_addr_form: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      cyc_q |-> (addr_q[23:4] == 20'hfffff && addr_q[0] && addr_q[3:1] == lvl_q))
      else $error("acknowledge address malformed");
   a_mask_latch: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (cyc_q && !$past(cyc_q)) |-> mask_q == addr_q[3:1])
      else $error("mask not loaded from acknowledged level");
   a_bus_error_line_nocontend: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (CE_I && state_q == ST_ARB && arb_done && alive == '0) |=> (bus_error_line_q && spur_q))
      else $error("no contender but no bus error");
   a_zero_spurious: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (CE_I && state_q == ST_ARB && arb_done && alive != '0 && win_field == 4'h0) |=> (spur_q && !done_q))
      else $error("zero field winner not spurious");
   a_tick_first: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (CE_I && state_q == ST_ARB && arb_done && alive[SIU] && tick_at && win_field != 4'h0) |=> (tick_ack_q && !ext_q))
      else $error("external served before tick timer");
   a_ext_only_siu: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      $rose(ext_q) |-> $past(alive[SIU]))
      else $error("external cycle without unit winning");
   a_mask_blocks: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (state_q == ST_IDLE && pend_lvl <= mask_q) |=> !stack_q)
      else $error("masked request started handling");
   a_ext_timeout: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (state_q == ST_EXTBUS) |-> ##[0:200] (state_q != ST_EXTBUS))
      else $error("external cycle never ended");
   a_mod_ack_onehot: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      $onehot0(mod_ack_q))
      else $error("more than one module acknowledged");
   a_cycle_closes: assert property (@(posedge CLOCK_I) disable iff (!ARST_N_I)
      (CE_I && state_q == ST_FINISH) |=> (!cyc_q && space_q == SPACE_IDLE))
      else $error("acknowledge cycle left open after its result");
endmodule : iak_top

// ===== iak_ext_dev.sv
// behavioural external interrupting device answering the acknowledge cycle
module iak_ext_dev (
   // clock and reset
   input wire logic clk_i,
   input wire logic arst_n_i,
   // bench control
   input wire logic req_i,
   input wire logic respond_i,
   input wire logic [2:0] level_i,
   input wire logic [7:0] vector_i,
   input wire logic [7:0] delay_i,
   // acknowledge bus
   input wire logic ext_cycle_i,
   input wire logic [2:0] ack_level_i,
   output logic [7:1] irq_n_o,
   output logic term_n_o,
   output logic [7:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pend_q;
   logic [7:0] cnt_q;

   // pin stays low until the device has answered once
   assign irq_n_o = pend_q ? ~(7'h01 << (level_i - 3'h1)) : 7'h7f;

   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         pend_q <= 1'b0;
         cnt_q <= 8'h00;
         term_n_o <= 1'b1;
         data_o <= 8'h00;
      end else begin
         if (req_i) begin
            pend_q <= 1'b1;
         end
         if (!ext_cycle_i) begin
            cnt_q <= 8'h00;
            if (!term_n_o) begin
               term_n_o <= 1'b1;
               // released bus must not keep the old vector
               data_o <= ~data_o;
            end
         end else if (pend_q && respond_i && ack_level_i == level_i) begin
            if (cnt_q == delay_i) begin
               term_n_o <= 1'b0;
               data_o <= vector_i;
               pend_q <= 1'b0;
            end else begin
               cnt_q <= cnt_q + 8'h01;
            end
         end
      end
   end
endmodule : iak_ext_dev

// ===== tb_iak.sv
// self-checking bench for the interrupt arbitration and acknowledge sequencer
module testbench import iak_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, arst_n, boundary, mask_load, arb_wr, tick_req, dev_req, dev_resp;
   logic [2:0] mask_data, tick_lvl, dev_lvl, arb_sel, space, mask;
   logic [3:0] arb_data, mod_req, mod_ack;
   logic [11:0] mod_lvl;
   logic [31:0] mod_vec;
   logic [7:0] tick_vec, dev_vec, dev_dly, ext_data, vector;
   logic [7:1] irq_n;
   logic term_n, ext_cycle, stack, ack_cycle, ack_done, bus_err, spur, tick_ack;
   logic [23:0] addr;
   logic [8:0] res;
   int r_n, num_errors, total_checks;

   iak_top #(.NMOD(4)) DUT (.CLOCK_I(clock), .ARST_N_I(arst_n), .CE_I(1'b1), .MOD_REQ_I(mod_req),
      .MOD_LEVEL_I(mod_lvl), .MOD_VECTOR_I(mod_vec), .MOD_ACK_O(mod_ack), .TICK_REQ_I(tick_req),
      .TICK_LEVEL_I(tick_lvl), .TICK_VECTOR_I(tick_vec), .TICK_ACK_O(tick_ack), .ARB_WR_I(arb_wr),
      .ARB_SEL_I(arb_sel), .ARB_DATA_I(arb_data), .IRQ_N_I(irq_n), .EXT_TERM_N_I(term_n),
      .EXT_DATA_I(ext_data), .EXT_CYCLE_O(ext_cycle), .BOUNDARY_I(boundary), .MASK_LOAD_I(mask_load),
      .MASK_DATA_I(mask_data), .STACK_O(stack), .ACK_CYCLE_O(ack_cycle), .ADDRESS_SPACE_CODE_O(space),
      .ADDR_O(addr), .INTERRUPT_PRIORITY_MASK_O(mask), .ACK_DONE_O(ack_done), .VECTOR_O(vector),
      .BUS_ERROR_LINE_O(bus_err), .SPURIOUS_O(spur));

   iak_ext_dev dev (.clk_i(clock), .arst_n_i(arst_n), .req_i(dev_req), .respond_i(dev_resp),
      .level_i(dev_lvl), .vector_i(dev_vec), .delay_i(dev_dly), .ext_cycle_i(ext_cycle),
      .ack_level_i(addr[3:1]), .irq_n_o(irq_n), .term_n_o(term_n), .data_o(ext_data));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic final_report();
      if (num_errors == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report

   // fields stay in 1..f and distinct per source
   task automatic set_field(input logic [2:0] sel, input logic [3:0] val);
      arb_wr = 1'b1;
      arb_sel = sel;
      arb_data = val;
      @(negedge clock);
      arb_wr = 1'b0;
      @(negedge clock);
   endtask : set_field

   task automatic set_mod(input int i, input logic [2:0] lvl, input logic [7:0] vec);
      mod_req[i] = 1'b1;
      mod_lvl[3*i +: 3] = lvl;
      mod_vec[8*i +: 8] = vec;
   endtask : set_mod

   // load is only honoured in idle, so callers wait out the finish cycle first
   task automatic unmask();
      mask_load = 1'b1;
      mask_data = 3'h0;
      @(negedge clock);
      mask_load = 1'b0;
   endtask : unmask

   task automatic pulse_dev();
      dev_req = 1'b1;
      @(negedge clock);
      dev_req = 1'b0;
   endtask : pulse_dev

   task automatic quiet(input int n);
      repeat (n) begin
         @(negedge clock);
         chk(stack, 24'h0);
      end
   endtask : quiet

   // follows one acknowledge from acceptance to its result pulse
   task automatic walk(input logic [2:0] lvl, input bit drop);
      int n;
      n = 0;
      while (stack !== 1'b1 && n < 20) begin
         @(negedge clock);
         n++;
      end
      chk(stack, 24'h1);
      if (drop) begin
         mod_req = 4'h0;
      end
      @(negedge clock);
      chk(ack_cycle, 24'h1);
      chk(space, SPACE_CPU);
      chk(addr, {ACK_ADDR_HI, lvl, ACK_ADDR_B0});
      chk(mask, lvl);
      r_n = 0;
      while ((ack_done | spur | bus_err) !== 1'b1 && r_n < 300) begin
         @(negedge clock);
         r_n++;
      end
      res = {ack_done, spur, bus_err, ext_cycle, tick_ack, mod_ack};
      @(negedge clock);
      chk(ack_cycle, 24'h0);
      chk(space, SPACE_IDLE);
   endtask : walk

   task automatic t_reset_spurious();
      chk(mask, MASK_RST);
      chk(addr, 24'h0);
      chk(space, SPACE_IDLE);
      set_mod(0, 3'h3, 8'h40);
      unmask();
      walk(3'h3, 1'b0);
      chk(res, 9'h080);
      mod_req = 4'h0;
      repeat (3) @(negedge clock);
   endtask : t_reset_spurious

   task automatic t_contend();
      set_field(3'h0, 4'h5);
      set_field(3'h1, 4'h9);
      set_field(3'h2, 4'h8);
      set_field(3'h3, 4'h1);
      set_mod(0, 3'h4, 8'h10);
      set_mod(1, 3'h4, 8'h11);
      set_mod(2, 3'h4, 8'h12);
      set_mod(3, 3'h2, 8'h13);
      unmask();
      walk(3'h4, 1'b0);
      chk(res, 9'h102);
      chk(vector, 8'h11);
      mod_req[2:0] = 3'h0;
      quiet(20);
      boundary = 1'b0;
      unmask();
      quiet(10);
      boundary = 1'b1;
      walk(3'h2, 1'b0);
      chk(res, 9'h108);
      chk(vector, 8'h13);
      mod_req = 4'h0;
      repeat (3) @(negedge clock);
   endtask : t_contend

   task automatic t_external();
      dev_lvl = 3'h5;
      dev_vec = 8'h5a;
      dev_dly = 8'h07;
      pulse_dev();
      set_mod(1, 3'h5, 8'h11);
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h120);
      chk(vector, 8'h5a);
      mod_req = 4'h0;
      repeat (3) @(negedge clock);
      set_field(3'h4, 4'h2);
      pulse_dev();
      set_mod(1, 3'h5, 8'h11);
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h102);
      chk(vector, 8'h11);
      mod_req = 4'h0;
      repeat (3) @(negedge clock);
      dev_dly = 8'h00;
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h120);
      chk(vector, 8'h5a);
      repeat (3) @(negedge clock);
   endtask : t_external

   task automatic t_timeout_tick();
      dev_resp = 1'b0;
      pulse_dev();
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h0e0);
      chk(r_n >= EXT_TIMEOUT_CYC, 24'h1);
      repeat (3) @(negedge clock);
      dev_resp = 1'b1;
      set_field(3'h4, 4'hf);
      tick_lvl = 3'h5;
      tick_vec = 8'h77;
      tick_req = 1'b1;
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h110);
      chk(vector, 8'h77);
      tick_req = 1'b0;
      repeat (3) @(negedge clock);
      unmask();
      walk(3'h5, 1'b0);
      chk(res, 9'h120);
      repeat (3) @(negedge clock);
   endtask : t_timeout_tick

   task automatic t_no_contender();
      set_mod(2, 3'h6, 8'h22);
      unmask();
      walk(3'h6, 1'b1);
      chk(res, 9'h0c0);
      repeat (3) @(negedge clock);
   endtask : t_no_contender

   initial begin
      repeat (5000) @(posedge clock);
      num_errors++;
      final_report();
   end

   initial begin
      num_errors = 0;
      total_checks = 0;
      {arst_n, mask_load, arb_wr, tick_req, dev_req} = 5'h00;
      {mask_data, tick_lvl, dev_lvl, arb_sel, arb_data} = 16'h0000;
      {mod_req, mod_lvl, mod_vec} = 48'h0;
      {tick_vec, dev_vec, dev_dly} = 24'h0;
      boundary = 1'b1;
      dev_resp = 1'b1;
      repeat (16) @(negedge clock);
      arst_n = 1'b1;
      @(negedge clock);
      t_reset_spurious();
      t_contend();
      t_external();
      t_timeout_tick();
      t_no_contender();
      final_report();
   end
endmodule : testbench
